/* sef_serdes_status_flags.sv */
// Sticky event flags, enables and interrupt of one serial channel
//
// Added by the designer: the APB register port and the address map.
`timescale 1ns/10ps
module sef_serdes_status_flags (
  input wire logic mclk,
  input wire logic sys_rst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [sef_pkg::ADDR_W-1:0] paddr,
  input wire logic [sef_pkg::DATA_W-1:0] pwdata,
  output logic [sef_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  // Channel events from shift, decode and line-monitor logic
  input wire logic preambleActive,
  input wire logic rxSymbolValid,
  input wire logic rxSymbolZero,
  input wire logic endOfPacketSeen,
  input wire logic syncPatternFound,
  input wire logic txHoldEmpty,
  input wire logic txShiftDone,
  input wire logic rxLine,
  input wire logic rxWordStored,
  input wire logic rxInProgress,
  input wire logic carrierDetect,
  // Results
  output logic txEopRequest,
  output logic irq
);
  import sef_pkg::*;

  sef_apb_state_t apbState_ff;
  logic [DATA_W-1:0] prdata_ff;
  logic pready_ff;
  logic pslverr_ff;
  logic [FLAG_W-1:0] flags_ff;
  logic [FLAG_W-1:0] nxt_flags_ff;
  logic [FLAG_W-1:0] enable_ff;
  logic [7:0] cfg_ff;
  logic crsEvt_ff;
  logic crsLast_ff;
  logic prevZero_ff;
  logic txEmptyLast_ff;
  logic lineLast_ff;
  logic [WIDTH_CNT_W-1:0] widthCnt_ff;
  logic txEopRequest_ff;
  logic irq_ff;
  logic [FLAG_W-1:0] setMask;
  logic [FLAG_W-1:0] clrMask;
  logic setupPhase;
  logic accessWrite;
  logic addrMapped;
  logic [DATA_W-1:0] readMux;
  logic lineMode;
  logic manchMode;
  logic [1:0] crsCtrl;
  logic dblZero;
  logic lineFall;
  logic widthInWindow;
  logic underrunEvt;
  logic crsEvtSet;
  logic crsIrq;

  // Mode decode from the configuration register
  assign lineMode = (cfg_ff[CFG_PROTO_LSB +: 2] == PROTO_10BT) ||
                    (cfg_ff[CFG_PROTO_LSB +: 2] == PROTO_USB);
  assign manchMode = cfg_ff[CFG_MANCH_BIT];
  assign crsCtrl = cfg_ff[CFG_CRS_LSB +: 2];

  // Bus phases; writes land only at the access edge
  assign setupPhase = psel && !penable && (apbState_ff == APB_IDLE);
  assign accessWrite = psel && penable && pwrite &&
                       (apbState_ff == APB_ACCESS) && !pslverr_ff;
  assign addrMapped = (paddr == ADDR_FLAGS) || (paddr == ADDR_ENABLE) ||
                      (paddr == ADDR_CFG) || (paddr == ADDR_CRS);

  // Read data; upper bits read as zero
  always_comb begin
    readMux = '0;
    case (paddr)
      ADDR_FLAGS: readMux[FLAG_W-1:0] = flags_ff;
      ADDR_ENABLE: readMux[FLAG_W-1:0] = enable_ff;
      ADDR_CFG: readMux[7:0] = cfg_ff;
      ADDR_CRS: begin
        readMux[CRS_EVT_BIT] = crsEvt_ff;
        readMux[CRS_LIVE_BIT] = carrierDetect;
      end
      default: readMux = '0;
    endcase
  end

  // APB slave: one wait-free access phase after every setup
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      apbState_ff <= APB_IDLE;
      pready_ff <= 1'h0;
      pslverr_ff <= 1'h0;
      prdata_ff <= '0;
    end else begin
      case (apbState_ff)
        APB_IDLE: begin
          if (setupPhase) begin
            apbState_ff <= APB_ACCESS;
            pready_ff <= 1'h1;
            pslverr_ff <= !addrMapped;
            prdata_ff <= pwrite ? '0 : readMux;
          end
        end
        APB_ACCESS: begin
          apbState_ff <= APB_IDLE;
          pready_ff <= 1'h0;
          pslverr_ff <= 1'h0;
        end
        default: begin
          apbState_ff <= APB_IDLE;
          pready_ff <= 1'h0;
          pslverr_ff <= 1'h0;
        end
      endcase
    end
  end

  // Enable and configuration registers
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      enable_ff <= ENABLE_RST;
      cfg_ff <= CFG_RST;
    end else if (accessWrite) begin
      if (paddr == ADDR_ENABLE) enable_ff <= pwdata[FLAG_W-1:0];
      if (paddr == ADDR_CFG) cfg_ff <= pwdata[7:0];
    end
  end

  // Preamble zero pairing; history is dropped outside the preamble
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      prevZero_ff <= 1'h0;
    end else if (!preambleActive) begin
      prevZero_ff <= 1'h0;
    end else if (rxSymbolValid) begin
      prevZero_ff <= rxSymbolZero;
    end
  end
  assign dblZero = manchMode && preambleActive && rxSymbolValid &&
                   rxSymbolZero && prevZero_ff;

  // Line pulse width counter, saturating so long pulses stay long
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      widthCnt_ff <= '0;
      lineLast_ff <= 1'h0;
    end else begin
      lineLast_ff <= rxLine;
      if (!rxLine) begin
        widthCnt_ff <= '0;
      end else if (widthCnt_ff != {WIDTH_CNT_W{1'h1}}) begin
        widthCnt_ff <= widthCnt_ff + WIDTH_CNT_W'(1);
      end
    end
  end
  assign lineFall = lineLast_ff && !rxLine;
  assign widthInWindow = (int'(widthCnt_ff) >= LINK_MIN_CYC) &&
                         (int'(widthCnt_ff) <= LINK_MAX_CYC);

  // Underrun: last word gone and nothing new loaded
  assign underrunEvt = txShiftDone && txHoldEmpty;

  // Event set mask
  always_comb begin
    setMask = '0;
    setMask[BIT_PREAMBLE_ERR] = dblZero;
    setMask[BIT_END_OF_PACKET] = endOfPacketSeen && lineMode;
    setMask[BIT_SYNC_DETECT] = syncPatternFound && lineMode;
    setMask[BIT_TX_BUF_EMPTY] = txHoldEmpty && !txEmptyLast_ff;
    setMask[BIT_TX_UNDERRUN] = underrunEvt;
    setMask[BIT_LINK_PULSE] = lineFall && widthInWindow;
    setMask[BIT_RX_BUF_FULL] = rxWordStored;
    setMask[BIT_RX_ACTIVITY] = rxWordStored || rxInProgress;
  end

  // Write-one-to-clear; a set in the same cycle wins
  assign clrMask = (accessWrite && paddr == ADDR_FLAGS) ?
                   pwdata[FLAG_W-1:0] : '0;
  assign nxt_flags_ff = (flags_ff & ~clrMask) | setMask;

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      flags_ff <= FLAGS_RST;
      txEmptyLast_ff <= 1'h1;
    end else begin
      flags_ff <= nxt_flags_ff;
      txEmptyLast_ff <= txHoldEmpty;
    end
  end

  // Carrier sense event, armed only by the interrupting encodings
  assign crsEvtSet =
    ((crsCtrl == CRS_IRQ_ON_DETECT) && carrierDetect && !crsLast_ff) ||
    ((crsCtrl == CRS_IRQ_ON_LOSS) && !carrierDetect && crsLast_ff);
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      crsEvt_ff <= 1'h0;
      crsLast_ff <= 1'h0;
    end else begin
      crsLast_ff <= carrierDetect;
      if (crsEvtSet) begin
        crsEvt_ff <= 1'h1;
      end else if (accessWrite && paddr == ADDR_CRS &&
                   pwdata[CRS_EVT_BIT]) begin
        crsEvt_ff <= 1'h0;
      end
    end
  end
  // Polling encodings never raise the line, even with a stale event
  assign crsIrq = crsEvt_ff && crsCtrl[1];

  // Registered outputs; irq trails the flags by one cycle
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      txEopRequest_ff <= 1'h0;
      irq_ff <= 1'h0;
    end else begin
      txEopRequest_ff <= underrunEvt && lineMode;
      irq_ff <= (|(flags_ff & enable_ff)) || crsIrq;
    end
  end

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign txEopRequest = txEopRequest_ff;
  assign irq = irq_ff;

  // Checks
  sequence preamblePairS;
    manchMode && preambleActive && rxSymbolValid && rxSymbolZero &&
      prevZero_ff;
  endsequence

  sequence apbSetupS;
    psel && !penable && apbState_ff == APB_IDLE;
  endsequence

  preamble_err_a: assert property (
    @(posedge mclk) disable iff (sys_rst)
    preamblePairS |=> flags_ff[BIT_PREAMBLE_ERR])
    else $error("preamble double zero did not set flag");

  payload_zero_a: assert property (
    @(posedge mclk) disable iff (sys_rst)
    $rose(flags_ff[BIT_PREAMBLE_ERR]) |-> $past(preambleActive))
    else $error("preamble flag set outside preamble");

  eop_mode_a: assert property (
    @(posedge mclk) disable iff (sys_rst)
    $rose(flags_ff[BIT_END_OF_PACKET]) |->
      $past(lineMode) && $past(endOfPacketSeen))
    else $error("end of packet flag set in wrong mode");

  sync_mode_a: assert property (
    @(posedge mclk) disable iff (sys_rst)
    syncPatternFound && lineMode |=> flags_ff[BIT_SYNC_DETECT])
    else $error("sync detect flag not set");

  tx_empty_a: assert property (
    @(posedge mclk) disable iff (sys_rst)
    $rose(txHoldEmpty) |=> flags_ff[BIT_TX_BUF_EMPTY])
    else $error("transmit empty flag not set");

  underrun_eop_a: assert property (
    @(posedge mclk) disable iff (sys_rst)
    txShiftDone && txHoldEmpty && lineMode |=>
      flags_ff[BIT_TX_UNDERRUN] && txEopRequest ##1
      (!txEopRequest || $past(underrunEvt)))
    else $error("underrun did not flag and request end of packet");

  no_eop_other_a: assert property (
    @(posedge mclk) disable iff (sys_rst)
    txEopRequest |-> $past(lineMode) && $past(txShiftDone))
    else $error("end of packet request without underrun");

  link_width_a: assert property (
    @(posedge mclk) disable iff (sys_rst)
    $rose(flags_ff[BIT_LINK_PULSE]) |->
      $past(widthCnt_ff) >= WIDTH_CNT_W'(LINK_MIN_CYC) &&
      $past(widthCnt_ff) <= WIDTH_CNT_W'(LINK_MAX_CYC) &&
      $past(lineFall))
    else $error("link pulse flag for out-of-window width");

  rx_full_a: assert property (
    @(posedge mclk) disable iff (sys_rst)
    rxWordStored |=> flags_ff[BIT_RX_BUF_FULL] &&
      flags_ff[BIT_RX_ACTIVITY])
    else $error("receive full or activity flag not set");

  rx_busy_a: assert property (
    @(posedge mclk) disable iff (sys_rst)
    rxInProgress |=> flags_ff[BIT_RX_ACTIVITY])
    else $error("receive activity flag not set");

  sticky_hold_a: assert property (
    @(posedge mclk) disable iff (sys_rst)
    flags_ff[BIT_LINK_PULSE] && !(accessWrite && paddr == ADDR_FLAGS)
      |=> flags_ff[BIT_LINK_PULSE])
    else $error("flag dropped without a clear");

  enable_write_a: assert property (
    @(posedge mclk) disable iff (sys_rst)
    accessWrite && paddr == ADDR_ENABLE |=>
      enable_ff == $past(pwdata[FLAG_W-1:0]))
    else $error("enable register not written");

  crs_detect_a: assert property (
    @(posedge mclk) disable iff (sys_rst)
    crsCtrl == CRS_IRQ_ON_DETECT && $rose(carrierDetect) &&
      $stable(cfg_ff) ##1 $stable(cfg_ff) |=> irq)
    else $error("carrier detect did not raise interrupt");

  irq_level_a: assert property (
    @(posedge mclk) disable iff (sys_rst)
    (|(flags_ff & enable_ff)) |=> irq)
    else $error("interrupt not raised for enabled flag");

  irq_quiet_a: assert property (
    @(posedge mclk) disable iff (sys_rst)
    !(|(flags_ff & enable_ff)) && !crsIrq |=> !irq)
    else $error("interrupt raised with no enabled flag");

  apb_ready_a: assert property (
    @(posedge mclk) disable iff (sys_rst)
    apbSetupS |=> pready ##1 !pready)
    else $error("bus access not answered in one cycle");
endmodule : sef_serdes_status_flags

/* sef_pkg.sv */
// Constants and types for the channel event flag block
package sef_pkg;
  // Register byte offsets on the APB
  localparam logic [7:0] ADDR_FLAGS = 8'h00;
  localparam logic [7:0] ADDR_ENABLE = 8'h04;
  localparam logic [7:0] ADDR_CFG = 8'h08;
  localparam logic [7:0] ADDR_CRS = 8'h0C;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int FLAG_W = 8;
  // Flag bit positions, shared by flag and enable registers
  localparam int BIT_PREAMBLE_ERR = 7;
  localparam int BIT_END_OF_PACKET = 6;
  localparam int BIT_SYNC_DETECT = 5;
  localparam int BIT_TX_BUF_EMPTY = 4;
  localparam int BIT_TX_UNDERRUN = 3;
  localparam int BIT_LINK_PULSE = 2;
  localparam int BIT_RX_BUF_FULL = 1;
  localparam int BIT_RX_ACTIVITY = 0;
  // Configuration register fields
  localparam int CFG_PROTO_LSB = 0;
  localparam int CFG_MANCH_BIT = 2;
  localparam int CFG_CRS_LSB = 4;
  localparam logic [1:0] PROTO_OFF = 2'h0;
  localparam logic [1:0] PROTO_10BT = 2'h1;
  localparam logic [1:0] PROTO_USB = 2'h2;
  localparam logic [1:0] PROTO_OTHER = 2'h3;
  // Carrier sense control encodings
  localparam logic [1:0] CRS_IRQ_ON_DETECT = 2'h2;
  localparam logic [1:0] CRS_IRQ_ON_LOSS = 2'h3;
  // Carrier register fields
  localparam int CRS_EVT_BIT = 0;
  localparam int CRS_LIVE_BIT = 1;
  // Reset values
  localparam logic [7:0] FLAGS_RST = 8'h00;
  localparam logic [7:0] ENABLE_RST = 8'h00;
  localparam logic [7:0] CFG_RST = 8'h00;
  // Link pulse width window
  localparam int CLK_PERIOD_NS = 40;
  localparam int LINK_MIN_NS = 75;
  localparam int LINK_MAX_NS = 250;
  localparam int LINK_MIN_CYC =
    (LINK_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int LINK_MAX_CYC = LINK_MAX_NS / CLK_PERIOD_NS;
  localparam int WIDTH_CNT_W = 4;
  // Bus slave states
  typedef enum logic [1:0] {
    APB_IDLE = 2'b01,
    APB_ACCESS = 2'b10
  } sef_apb_state_t;
endpackage : sef_pkg

/* sef_line_model.sv */
// Model of the serial line and buffers that feed the channel events
`timescale 1ns/10ps
module sef_line_model (
  input wire logic mclk,
  output logic preambleActive,
  output logic rxSymbolValid,
  output logic rxSymbolZero,
  output logic endOfPacketSeen,
  output logic syncPatternFound,
  output logic txHoldEmpty,
  output logic txShiftDone,
  output logic rxLine,
  output logic rxWordStored,
  output logic rxInProgress,
  output logic carrierDetect
);
  // Idle line; the holding buffer starts empty, as after reset
  initial begin
    {preambleActive, rxSymbolValid, rxSymbolZero, endOfPacketSeen} = 4'h0;
    {syncPatternFound, txShiftDone, rxLine, rxWordStored} = 4'h0;
    {rxInProgress, carrierDetect} = 2'h0;
    txHoldEmpty = 1'b1;
  end
  // Slow levels move together, just after an edge
  task automatic levels(input logic [3:0] v);
    @(posedge mclk);
    {preambleActive, txHoldEmpty, rxInProgress, carrierDetect} <= v;
  endtask : levels
  // One-cycle strobes; the symbol value is garbled once valid drops
  task automatic strobe(input logic [4:0] s, input logic z);
    @(posedge mclk);
    {rxSymbolValid, endOfPacketSeen, syncPatternFound} <= s[4:2];
    {txShiftDone, rxWordStored} <= s[1:0];
    rxSymbolZero <= z;
    @(posedge mclk);
    {rxSymbolValid, endOfPacketSeen, syncPatternFound} <= 3'h0;
    {txShiftDone, rxWordStored} <= 2'h0;
    rxSymbolZero <= ~z;
  endtask : strobe
  // Receive line high for n cycles, then low
  task automatic pulse(input int n);
    @(posedge mclk);
    rxLine <= 1'b1;
    repeat (n) @(posedge mclk);
    rxLine <= 1'b0;
  endtask : pulse
endmodule : sef_line_model

/* tb.sv */
// Self-checking bench for the channel event flag block
`timescale 1ns/10ps
module tb;
  import sef_pkg::*;
  logic mclk = 1'b0;
  logic sysRst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [DATA_W-1:0] pwdata = '0;
  logic [DATA_W-1:0] prdata, v, rd;
  logic pready, pslverr, txEopRequest, irq, er;
  logic preambleActive, rxSymbolValid, rxSymbolZero, endOfPacketSeen;
  logic syncPatternFound, txHoldEmpty, txShiftDone, rxLine;
  logic rxWordStored, rxInProgress, carrierDetect;
  logic [1:0] cs;
  int num_errors = 0;
  int checks_done = 0;
  int seed = 97;
  int eopCount = 0;
  int n;
  always #20 mclk = ~mclk;
  // Count end-of-packet requests; each lasts a single cycle
  always @(posedge mclk) if (txEopRequest === 1'b1) eopCount <= eopCount + 1;
  sef_serdes_status_flags dut (.mclk, .sys_rst(sysRst), .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .preambleActive,
    .rxSymbolValid, .rxSymbolZero, .endOfPacketSeen, .syncPatternFound,
    .txHoldEmpty, .txShiftDone, .rxLine, .rxWordStored, .rxInProgress,
    .carrierDetect, .txEopRequest, .irq);
  sef_line_model line (.mclk, .preambleActive, .rxSymbolValid,
    .rxSymbolZero, .endOfPacketSeen, .syncPatternFound, .txHoldEmpty,
    .txShiftDone, .rxLine, .rxWordStored, .rxInProgress, .carrierDetect);
  task automatic print_verdict();
    if (num_errors == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : print_verdict
  task automatic check(input string what, input logic [31:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // One APB transfer; the wait for pready is bounded
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    bit done;
    done = 0;
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    for (int i = 0; i < 16 && !done; i++) begin
      @(posedge mclk);
      if (pready === 1'b1) begin
        done = 1;
        rd = prdata;
        er = pslverr;
      end
    end
    psel <= 1'b0;
    penable <= 1'b0;
    if (!done) begin
      num_errors++;
      print_verdict();
    end
  endtask : apb
  // Upper bits of every register read as zero
  task automatic rdchk(input logic [7:0] a, input logic [7:0] e,
                       input string nm);
    apb(1'b0, a, 32'h0000_0000);
    check(nm, rd, {24'h00_0000, e});
  endtask : rdchk
  function automatic logic [7:0] exp_link(input int w);
    return (w >= LINK_MIN_CYC && w <= LINK_MAX_CYC) ? 8'h04 : 8'h00;
  endfunction : exp_link
  function automatic logic [7:0] exp_proto(input int p);
    return (p == PROTO_10BT || p == PROTO_USB) ? 8'h68 : 8'h08;
  endfunction : exp_proto
  initial begin
    repeat (10) @(posedge mclk);
    sysRst <= 1'b0;
    // Reset values, then an unmapped place
    rdchk(ADDR_FLAGS, FLAGS_RST, "flags reset");
    rdchk(ADDR_ENABLE, ENABLE_RST, "enable reset");
    rdchk(ADDR_CFG, CFG_RST, "cfg reset");
    rdchk(8'h10, 8'h00, "unmapped data");
    check("unmapped slverr", er, 1'b1);
    for (int k = 0; k < 4; k++) begin
      v = $random(seed);
      apb(1'b1, ADDR_ENABLE, v);
      rdchk(ADDR_ENABLE, v[7:0], "enable");
    end
    apb(1'b1, ADDR_ENABLE, 32'h0000_0000);
    // Link pulse widths: window edges first, then random ones
    for (int j = 0; j < 10; j++) begin
      n = j < 4 ? 1 + 5 * (j / 2) + j % 2 : 1 + $unsigned($random(seed)) % 8;
      apb(1'b1, ADDR_FLAGS, 32'h0000_00FF);
      line.pulse(n);
      rdchk(ADDR_FLAGS, exp_link(n), "link pulse");
    end
    // Every protocol code: packet flags and underrun end-of-packet
    for (int p = 0; p < 4; p++) begin
      apb(1'b1, ADDR_CFG, p);
      apb(1'b1, ADDR_FLAGS, 32'h0000_00FF);
      eopCount = 0;
      line.strobe(5'b0_1110, 1'b0);
      rdchk(ADDR_FLAGS, exp_proto(p), "proto flags");
      check("eop request", eopCount, int'(p == 1 || p == 2));
    end
    // Double zero in preamble, broken pair, double zero in data
    apb(1'b1, ADDR_CFG, 32'h0000_0004);
    for (int c = 0; c < 3; c++) begin
      apb(1'b1, ADDR_FLAGS, 32'h0000_00FF);
      line.levels({c != 2, 3'b100});
      line.strobe(5'b1_0000, 1'b1);
      if (c == 1) line.strobe(5'b1_0000, 1'b0);
      line.strobe(5'b1_0000, 1'b1);
      line.levels(4'b0100);
      rdchk(ADDR_FLAGS, c == 0 ? 8'h80 : 8'h00, "preamble");
    end
    // Shift done with a full buffer is no underrun; a stored word is news
    line.levels(4'b0000);
    apb(1'b1, ADDR_FLAGS, 32'h0000_00FF);
    line.strobe(5'b0_0011, 1'b0);
    rdchk(ADDR_FLAGS, 8'h03, "rx full no underrun");
    line.levels(4'b0110);
    line.levels(4'b0100);
    rdchk(ADDR_FLAGS, 8'h13, "empty and busy");
    // Interrupt raised, kept sticky, masked, then cleared
    apb(1'b1, ADDR_FLAGS, 32'h0000_00FF);
    apb(1'b1, ADDR_ENABLE, 32'h0000_0004);
    line.pulse(3);
    repeat (3) @(posedge mclk);
    check("irq set", irq, 1'b1);
    apb(1'b1, ADDR_FLAGS, 32'h0000_00FB);
    rdchk(ADDR_FLAGS, 8'h04, "sticky");
    apb(1'b1, ADDR_ENABLE, 32'h0000_0000);
    repeat (2) @(posedge mclk);
    check("irq masked", irq, 1'b0);
    apb(1'b1, ADDR_ENABLE, 32'h0000_0004);
    apb(1'b1, ADDR_FLAGS, 32'h0000_0004);
    repeat (2) @(posedge mclk);
    check("irq cleared", irq, 1'b0);
    // Carrier codes: detect, loss, polling
    for (int m = 0; m < 3; m++) begin
      cs = m == 0 ? CRS_IRQ_ON_DETECT : m == 1 ? CRS_IRQ_ON_LOSS : 2'h1;
      apb(1'b1, ADDR_CFG, 32'(cs) << CFG_CRS_LSB);
      apb(1'b1, ADDR_CRS, 32'h0000_0001);
      line.levels({3'b010, m != 1});
      repeat (3) @(posedge mclk);
      check("carrier irq", irq, cs[1]);
      rdchk(ADDR_CRS, {6'h00, m != 1, cs[1]}, "carrier");
    end
    // Mid-run reset drops a raised interrupt, the flags and the enables
    line.pulse(3);
    repeat (2) @(posedge mclk);
    sysRst <= 1'b1;
    repeat (2) @(posedge mclk);
    sysRst <= 1'b0;
    check("irq after reset", irq, 1'b0);
    rdchk(ADDR_FLAGS, FLAGS_RST, "flags after reset");
    rdchk(ADDR_ENABLE, ENABLE_RST, "enable after reset");
    print_verdict();
  end
endmodule : tb
